// file: sim/tsm_host_model.sv
// Bus host model driving the serial clock and data lines of the monitor.
`timescale 1ns/1ps
`default_nettype none
module tsm_host_model (
    input wire logic clock,
    input wire logic dev_pull,
    output logic scl,
    output wire logic sda
);
    logic host_pull = 1'b0;
    // Open-drain line with a pull-up: high unless either side pulls it low.
    assign sda = !(host_pull || dev_pull);
    initial scl = 1'b1;
    task automatic step(input logic c, input logic p);
        scl <= c;
        host_pull <= p;
        repeat (10) @(posedge clock);
    endtask
    task automatic bit_io(input logic b, output logic got);
        step(1'b0, host_pull);
        step(1'b0, !b);
        step(1'b1, !b);
        got = sda;
    endtask
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, ack);
    endtask
    task automatic frame(input logic [7:0] a0, input logic [7:0] a1, input logic [7:0] a2,
            input logic three, output logic [7:0] rx);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        byte_io(a0, rx);
        byte_io(a1, rx);
        if (three) begin
            byte_io(a2, rx);
        end
        step(1'b0, host_pull);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
endmodule // tsm_host_model
`default_nettype wire

// file: sim/tsm_monitor_regs_tb.sv
// Self-checking bench for the monitor register block.
`timescale 1ns/1ps
`default_nettype none
module tsm_monitor_regs_tb;
    logic clock = 1'b0, adc_clock = 1'b0, rst = 1'b1, adc_valid = 1'b0;
    logic [1:0] adc_channel = 2'h0;
    logic [11:0] adc_temp = 12'h000;
    logic [3:0] req = 4'h0;
    logic [7:0] v;
    int fail_count = 0, tests_run = 0;
    wire scl, sda, sda_oe, rdy, halt, ext, pin;
    // Ops: 0 read and compare, 1 write, 2 converter word, 3 alarm case, 5 end of a test.
    logic [23:0] prog [] = '{
        24'h003000, 24'h024000, 24'h010000, 24'h001000, 24'h033000, 24'h030000,
        24'h500001, 24'h200064, 24'h000019, 24'h200fec, 24'h000000,
        24'h200258, 24'h00007f, 24'h109004, 24'h003004, 24'h500002,
        24'h200000, 24'h000040, 24'h200f24, 24'h000009, 24'h200258, 24'h0000d6,
        24'h1000aa, 24'h0000d6, 24'h109000, 24'h202192, 24'h033080, 24'h030064,
        24'h2010cb, 24'h0100c0, 24'h201029, 24'h001032, 24'h00100a, 24'h500003,
        24'h109008, 24'h010080, 24'h001064, 24'h1090ff, 24'h0030ef, 24'h12407f,
        24'h024000, 24'h500004, 24'h300101, 24'h380100, 24'h302200, 24'h302401,
        24'h301400, 24'h320100, 24'h3a0801, 24'h304101, 24'h340100, 24'h500005,
        24'h109000, 24'h124080, 24'h109004, 24'h003000, 24'h024080, 24'h500006
    };
    always #2.5 clock = ~clock;
    initial #1.3 forever #3 adc_clock = ~adc_clock;
    tsm_host_model host (.clock(clock), .dev_pull(sda_oe), .scl(scl), .sda(sda));
    tsm_monitor_regs dut (.clock(clock), .rst(rst), .adc_clock(adc_clock), .scl(scl),
        .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .adc_valid(adc_valid),
        .adc_channel(adc_channel), .adc_temp(adc_temp), .adc_ready(rdy),
        .conversion_halt(halt), .range_extended(ext), .local_alarm_req(req[0]),
        .remote_one_alarm_req(req[1]), .remote_two_alarm_req(req[2]), .overtemp_req(1'b0),
        .second_overtemp_req(req[3]), .overtemp_comparator_out(),
        .overtemp_comparator_out_oe(), .shared_pin_out(), .shared_pin_oe(pin));
    task automatic tally_and_finish();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.frame({tsm_pkg::BUS_ADDRESS, 1'b0}, a, d, 1'b1, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.frame({tsm_pkg::BUS_ADDRESS, 1'b0}, a, 8'h00, 1'b0, v);
        host.frame({tsm_pkg::BUS_ADDRESS, 1'b1}, 8'hff, 8'h00, 1'b0, v);
        check(v, e);
    endtask
    // Offers one quarter-degree word to the converter port and lets it settle.
    task automatic push(input logic [1:0] ch, input logic [11:0] q);
        @(posedge adc_clock);
        for (int i = 0; i < 60 && rdy !== 1'b1; i++) @(posedge adc_clock);
        adc_valid <= 1'b1;
        adc_channel <= ch;
        adc_temp <= q;
        @(posedge adc_clock);
        adc_valid <= 1'b0;
        repeat (30) @(posedge clock);
    endtask
    task automatic run(input logic [23:0] op);
        logic [7:0] a;
        logic [11:0] d;
        a = op[19:12];
        d = op[11:0];
        case (op[23:20])
            4'h0: rd(a, d[7:0]);
            4'h1: wr(a, d[7:0]);
            4'h2: push(a[1:0], d);
            4'h5: $display("test %0d done", d);
            default: begin
                wr(8'h09, a);
                req <= d[11:8];
                repeat (4) @(posedge clock);
                check({4'h0, rdy, halt, ext, pin}, {4'h0, !a[6], a[6], a[2], d[0]});
            end
        endcase
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (20) @(posedge clock);
        host.frame({tsm_pkg::BUS_ADDRESS, 1'b1}, 8'hff, 8'h00, 1'b0, v);
        check(v, 8'h00);
        foreach (prog[i]) run(prog[i]);
        tally_and_finish();
    end
    initial begin
        #450000;
        fail_count++;
        tally_and_finish();
    end
endmodule // tsm_monitor_regs_tb
`default_nettype wire

// file: src/tsm_monitor_regs.sv
// Bus-side register logic of the three-channel temperature monitor.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Results use 0..127 scale when range bit clear, -64..191 when set.
// - After a range change, the next measurement is valid on the new scale.
// - Default scale stores unsigned degrees, clamped to 0 and 127.
// - Extended scale stores temperature plus 64 as unsigned binary.
// - Range may change anytime; next result written uses the new format.
// - Limit values are never converted when the range changes.
// - Every register is eight bits wide.
// - First byte of each bus write loads the address pointer.
// - Second write byte goes to the pointed register; reads return it.
// - Pointer resets to 0x00, so early reads return local result.
// - Result registers change only from the converter; host writes ignored.
// - Results sit at 0x00, 0x01, 0x10, 0x30 and 0x33.
// - Alias bit set makes remote-one addresses return remote-two values.
// - All five result registers reset to 0x00.
// - First configuration reads at 0x03 and is written at 0x09.
// - Global inhibit suppresses alarm output, except in second overtemp role.
// - Halt bit stops conversions; bus works; alarm outputs go inactive.
// - Pin-function bit picks alarm role (clear) or second overtemp (set).
// - Bit 1 suppresses alarms from remote-one violations; default 0.
// - Bit 0 suppresses alarms from remote-two violations; default 0.
// - Second configuration at 0x24; bit 7 freezes lockable registers until reset.
// - Reading a remote low byte holds its high byte until that is read.
module tsm_monitor_regs #(
    parameter int TEMP_W = tsm_pkg::TEMP_W,
    parameter logic [6:0] BUS_ADDRESS = tsm_pkg::BUS_ADDRESS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic adc_clock,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic adc_valid,
    input wire logic [1:0] adc_channel,
    input wire logic [TEMP_W-1:0] adc_temp,
    output logic adc_ready,
    output logic conversion_halt,
    output logic range_extended,
    input wire logic local_alarm_req,
    input wire logic remote_one_alarm_req,
    input wire logic remote_two_alarm_req,
    input wire logic overtemp_req,
    input wire logic second_overtemp_req,
    output logic overtemp_comparator_out,
    output logic overtemp_comparator_out_oe,
    output logic shared_pin_out,
    output logic shared_pin_oe
);
    import tsm_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_ADDR_ACK = 7'b0000100,
        ST_WR_BYTE = 7'b0001000,
        ST_WR_ACK = 7'b0010000,
        ST_RD_BYTE = 7'b0100000,
        ST_RD_ACK = 7'b1000000
    } tsm_bus_state_t;

    tsm_bus_state_t state_reg;
    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] shift_reg, pointer_reg, read_data;
    logic [3:0] count_reg;
    logic rw_reg, first_byte_reg, acked_reg;
    logic write_commit, read_load, read_done;
    logic [7:0] cfg1_reg, cfg2_reg;
    logic [7:0] local_reg, r1_high_reg, r1_low_reg, r2_high_reg, r2_low_reg;
    logic [7:0] r1_pend_reg, r2_pend_reg;
    logic r1_hold_reg, r2_hold_reg, r1_pend_valid, r2_pend_valid;
    logic res_valid;
    logic [1:0] res_channel;
    logic [TEMP_W-1:0] res_temp;
    logic [15:0] formatted;
    logic alias_on, locked;

    assign alias_on = cfg1_reg[CFG1_ALIAS];
    assign locked = cfg2_reg[CFG2_LOCK];
    assign conversion_halt = cfg1_reg[CFG1_HALT];
    assign range_extended = cfg1_reg[CFG1_RANGE];
    assign sda_out = 1'b0;
    assign overtemp_comparator_out = 1'b0;
    assign shared_pin_out = 1'b0;

    // Bus pins pass two flip-flops; the third copy is only for edge detection.
    always_ff @(posedge clock) begin
        scl_s1 <= scl;
        scl_s2 <= scl_s1;
        scl_d <= scl_s2;
        sda_s1 <= sda_in;
        sda_s2 <= sda_s1;
        sda_d <= sda_s2;
    end

    assign scl_rise = scl_s2 && !scl_d;
    assign scl_fall = !scl_s2 && scl_d;
    assign start_seen = scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_seen = scl_s2 && scl_d && !sda_d && sda_s2;
    assign write_commit = (state_reg == ST_WR_BYTE) && scl_fall && (count_reg == BITS_PER_BYTE);
    assign read_load = scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg)
        || (state_reg == ST_RD_ACK && acked_reg));
    assign read_done = (state_reg == ST_RD_BYTE) && scl_fall && (count_reg == LAST_READ_BIT);

    // Byte engine of the serial slave; no auto-increment of the pointer.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            count_reg <= 4'h0;
            rw_reg <= 1'b0;
            first_byte_reg <= 1'b0;
            acked_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= ST_ADDR;
            count_reg <= 4'h0;
        end else if (stop_seen) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    count_reg <= 4'h0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2};
                        count_reg <= count_reg + 4'h1;
                    end else if (scl_fall && count_reg == BITS_PER_BYTE) begin
                        rw_reg <= shift_reg[0];
                        first_byte_reg <= 1'b1;
                        state_reg <= (shift_reg[7:1] == BUS_ADDRESS) ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        count_reg <= 4'h0;
                        if (rw_reg) begin
                            shift_reg <= read_data;
                            state_reg <= ST_RD_BYTE;
                        end else begin
                            state_reg <= ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2};
                        count_reg <= count_reg + 4'h1;
                    end else if (write_commit) begin
                        state_reg <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK: begin
                    if (scl_fall) begin
                        first_byte_reg <= 1'b0;
                        count_reg <= 4'h0;
                        state_reg <= ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE: begin
                    if (read_done) begin
                        state_reg <= ST_RD_ACK;
                    end else if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        count_reg <= count_reg + 4'h1;
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        acked_reg <= !sda_s2;
                    end else if (scl_fall) begin
                        count_reg <= 4'h0;
                        if (acked_reg) begin
                            shift_reg <= read_data;
                            state_reg <= ST_RD_BYTE;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Pulls data low for acknowledge and for zero bits of a read byte.
    always_ff @(posedge clock) begin
        if (rst) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= (state_reg == ST_ADDR_ACK) || (state_reg == ST_WR_ACK)
                || ((state_reg == ST_RD_BYTE) && !shift_reg[7]);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pointer_reg <= POINTER_RESET;
        end else if (write_commit && first_byte_reg) begin
            pointer_reg <= shift_reg;
        end
    end

    // Lockable settings only take writes while the lock bit is clear.
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg1_reg <= CFG1_RESET;
            cfg2_reg <= CFG2_RESET;
        end else if (write_commit && !first_byte_reg && !locked) begin
            if (pointer_reg == ADDR_CFG1_WR) begin
                cfg1_reg <= shift_reg & CFG1_MASK;
            end
            if (pointer_reg == ADDR_CFG2) begin
                cfg2_reg <= shift_reg & CFG2_MASK;
            end
        end
    end

    always_comb begin
        case (pointer_reg)
            ADDR_LOCAL: read_data = local_reg;
            ADDR_R1_HIGH: read_data = alias_on ? r2_high_reg : r1_high_reg;
            ADDR_R1_LOW: read_data = alias_on ? r2_low_reg : r1_low_reg;
            ADDR_R2_HIGH: read_data = r2_high_reg;
            ADDR_R2_LOW: read_data = r2_low_reg;
            ADDR_CFG1_RD: read_data = cfg1_reg;
            ADDR_CFG2: read_data = cfg2_reg;
            default: read_data = 8'h00;
        endcase
    end

    tsm_result_xfer #(
        .TEMP_W(TEMP_W)
    ) u_xfer (
        .clock(clock),
        .rst(rst),
        .adc_clock(adc_clock),
        .halt(conversion_halt),
        .adc_valid(adc_valid),
        .adc_channel(adc_channel),
        .adc_temp(adc_temp),
        .adc_ready(adc_ready),
        .res_valid(res_valid),
        .res_channel(res_channel),
        .res_temp(res_temp)
    );

    // Formats with the range bit standing when the result arrives, so a change shows from the next result on.
    function automatic logic [15:0] tsm_format(input logic [TEMP_W-1:0] t, input logic ext);
        logic signed [10:0] v;
        logic signed [10:0] top;
        logic [7:0] high, low;
        v = $signed(t[TEMP_W-1:FRAC_W]) + (ext ? EXT_OFFSET : 11'sd0);
        top = ext ? EXT_MAX : BIN_MAX;
        if (v < 11'sd0) begin
            high = 8'h00;
            low = 8'h00;
        end else if (v > top) begin
            high = top[7:0];
            low = 8'h00;
        end else begin
            high = v[7:0];
            low = {t[FRAC_W-1:0], 6'h00};
        end
        return {high, low};
    endfunction

    assign formatted = tsm_format(res_temp, cfg1_reg[CFG1_RANGE]);

    // The range bit only steers this formatting; limit storage lies outside and is never touched.
    always_ff @(posedge clock) begin
        if (rst) begin
            local_reg <= RESULT_RESET;
            r1_low_reg <= RESULT_RESET;
            r2_low_reg <= RESULT_RESET;
        end else if (res_valid) begin
            if (res_channel == CHAN_LOCAL) begin
                local_reg <= formatted[15:8];
            end
            if (res_channel == CHAN_R1) begin
                r1_low_reg <= formatted[7:0];
            end
            if (res_channel == CHAN_R2) begin
                r2_low_reg <= formatted[7:0];
            end
        end
    end

    // A low-byte read holds the high byte; a newer high byte waits until the held one is read.
    always_ff @(posedge clock) begin
        if (rst) begin
            r1_high_reg <= RESULT_RESET;
            r1_hold_reg <= 1'b0;
            r1_pend_reg <= RESULT_RESET;
            r1_pend_valid <= 1'b0;
        end else begin
            if (read_done && pointer_reg == ADDR_R1_LOW && !alias_on) begin
                r1_hold_reg <= 1'b1;
            end else if (read_done && pointer_reg == ADDR_R1_HIGH && !alias_on) begin
                r1_hold_reg <= 1'b0;
            end
            if (res_valid && res_channel == CHAN_R1 && r1_hold_reg) begin
                r1_pend_reg <= formatted[15:8];
                r1_pend_valid <= 1'b1;
            end else if (res_valid && res_channel == CHAN_R1) begin
                r1_high_reg <= formatted[15:8];
                r1_pend_valid <= 1'b0;
            end else if (!r1_hold_reg && r1_pend_valid) begin
                r1_high_reg <= r1_pend_reg;
                r1_pend_valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r2_high_reg <= RESULT_RESET;
            r2_hold_reg <= 1'b0;
            r2_pend_reg <= RESULT_RESET;
            r2_pend_valid <= 1'b0;
        end else begin
            if (read_done && (pointer_reg == ADDR_R2_LOW
                    || (pointer_reg == ADDR_R1_LOW && alias_on))) begin
                r2_hold_reg <= 1'b1;
            end else if (read_done && (pointer_reg == ADDR_R2_HIGH
                    || (pointer_reg == ADDR_R1_HIGH && alias_on))) begin
                r2_hold_reg <= 1'b0;
            end
            if (res_valid && res_channel == CHAN_R2 && r2_hold_reg) begin
                r2_pend_reg <= formatted[15:8];
                r2_pend_valid <= 1'b1;
            end else if (res_valid && res_channel == CHAN_R2) begin
                r2_high_reg <= formatted[15:8];
                r2_pend_valid <= 1'b0;
            end else if (!r2_hold_reg && r2_pend_valid) begin
                r2_high_reg <= r2_pend_reg;
                r2_pend_valid <= 1'b0;
            end
        end
    end

    // Alarm pin drivers; both are released while conversions are halted.
    always_ff @(posedge clock) begin
        if (rst) begin
            shared_pin_oe <= 1'b0;
            overtemp_comparator_out_oe <= 1'b0;
        end else if (conversion_halt) begin
            shared_pin_oe <= 1'b0;
            overtemp_comparator_out_oe <= 1'b0;
        end else begin
            overtemp_comparator_out_oe <= overtemp_req;
            if (cfg1_reg[CFG1_PIN_SELECT]) begin
                shared_pin_oe <= second_overtemp_req;
            end else begin
                shared_pin_oe <= !cfg1_reg[CFG1_ALARM_INHIBIT] && (local_alarm_req
                    || (remote_one_alarm_req && !cfg1_reg[CFG1_R1_INHIBIT])
                    || (remote_two_alarm_req && !cfg1_reg[CFG1_R2_INHIBIT]));
            end
        end
    end

    sequence s_low_read;
        read_done && pointer_reg == ADDR_R1_LOW && !alias_on;
    endsequence

    sequence s_fresh_r1;
        res_valid && res_channel == CHAN_R1;
    endsequence

    ptr_reset_a: assert property (@(posedge clock) rst |=> pointer_reg == 8'h00 && local_reg == 8'h00)
        else $error("pointer or result not cleared by reset");
    ptr_load_a: assert property (@(posedge clock) disable iff (rst)
        write_commit && first_byte_reg |=> pointer_reg == $past(shift_reg))
        else $error("first write byte did not load the pointer");
    result_ro_a: assert property (@(posedge clock) disable iff (rst)
        write_commit && !res_valid |=> $stable(local_reg) && $stable(r2_low_reg))
        else $error("host write changed a result register");
    bin_clamp_a: assert property (@(posedge clock) disable iff (rst)
        res_valid && res_channel == CHAN_LOCAL && !range_extended |=> local_reg <= 8'h7f)
        else $error("binary result above 127");
    ext_offset_a: assert property (@(posedge clock) disable iff (rst)
        res_valid && res_channel == CHAN_LOCAL && range_extended && res_temp == 12'h000
        |=> local_reg == 8'h40)
        else $error("zero degrees not stored as 0x40");
    alias_read_a: assert property (@(posedge clock) disable iff (rst)
        read_load && pointer_reg == ADDR_R1_HIGH && alias_on |=> shift_reg == $past(r2_high_reg))
        else $error("alias read did not return remote two");
    inhibit_all_a: assert property (@(posedge clock) disable iff (rst)
        cfg1_reg[7] && !cfg1_reg[5] ##1 cfg1_reg[7] && !cfg1_reg[5] |-> !shared_pin_oe)
        else $error("alarm driven while inhibited");
    halt_quiet_a: assert property (@(posedge clock) disable iff (rst)
        conversion_halt |=> !shared_pin_oe && !overtemp_comparator_out_oe)
        else $error("alarm pins driven in halt");
    lock_freeze_a: assert property (@(posedge clock) disable iff (rst)
        locked |=> $stable(cfg1_reg) && $stable(cfg2_reg))
        else $error("locked settings changed");
    hold_high_a: assert property (@(posedge clock) disable iff (rst)
        (r1_hold_reg && !read_done) ##0 s_fresh_r1 |=> $stable(r1_high_reg))
        else $error("held high byte was overwritten");
endmodule // tsm_monitor_regs
`default_nettype wire

// file: src/tsm_pkg.sv
// Package with register map, field positions and reset values of the temperature monitor.
package tsm_pkg;
    localparam int TEMP_W = 12;
    localparam int FRAC_W = 2;
    localparam logic [7:0] ADDR_LOCAL = 8'h00;
    localparam logic [7:0] ADDR_R1_HIGH = 8'h01;
    localparam logic [7:0] ADDR_CFG1_RD = 8'h03;
    localparam logic [7:0] ADDR_CFG1_WR = 8'h09;
    localparam logic [7:0] ADDR_R1_LOW = 8'h10;
    localparam logic [7:0] ADDR_CFG2 = 8'h24;
    localparam logic [7:0] ADDR_R2_HIGH = 8'h30;
    localparam logic [7:0] ADDR_R2_LOW = 8'h33;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] CFG1_RESET = 8'h00;
    localparam logic [7:0] CFG2_RESET = 8'h00;
    localparam logic [7:0] CFG1_MASK = 8'hef;
    localparam logic [7:0] CFG2_MASK = 8'h80;
    localparam int CFG1_ALARM_INHIBIT = 7;
    localparam int CFG1_HALT = 6;
    localparam int CFG1_PIN_SELECT = 5;
    localparam int CFG1_ALIAS = 3;
    localparam int CFG1_RANGE = 2;
    localparam int CFG1_R1_INHIBIT = 1;
    localparam int CFG1_R2_INHIBIT = 0;
    localparam int CFG2_LOCK = 7;
    localparam logic [1:0] CHAN_LOCAL = 2'h0;
    localparam logic [1:0] CHAN_R1 = 2'h1;
    localparam logic [1:0] CHAN_R2 = 2'h2;
    localparam logic signed [10:0] EXT_OFFSET = 11'sd64;
    localparam logic signed [10:0] BIN_MAX = 11'sd127;
    localparam logic signed [10:0] EXT_MAX = 11'sd255;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_READ_BIT = 4'h7;
    // Bus address of the device; the default value is arbitrary.
    localparam logic [6:0] BUS_ADDRESS = 7'h48;
endpackage

// file: src/tsm_result_xfer.sv
// Carries converter results from the converter clock domain to the register clock domain.
`timescale 1ns/1ps
`default_nettype none
module tsm_result_xfer #(
    parameter int TEMP_W = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic adc_clock,
    input wire logic halt,
    input wire logic adc_valid,
    input wire logic [1:0] adc_channel,
    input wire logic [TEMP_W-1:0] adc_temp,
    output logic adc_ready,
    output logic res_valid,
    output logic [1:0] res_channel,
    output logic [TEMP_W-1:0] res_temp
);
    logic adc_rst_s1, adc_rst_s2, halt_s1, halt_s2, ack_s1, ack_s2, req_tog;
    logic req_s1, req_s2, ack_tog;
    logic [1:0] cap_channel;
    logic [TEMP_W-1:0] cap_temp;

    always_ff @(posedge adc_clock) begin
        adc_rst_s1 <= rst;
        adc_rst_s2 <= adc_rst_s1;
        halt_s1 <= halt;
        halt_s2 <= halt_s1;
        ack_s1 <= ack_tog;
        ack_s2 <= ack_s1;
    end

    // A sample is taken only when the previous one has been acknowledged and no halt stands.
    assign adc_ready = (req_tog == ack_s2) && !halt_s2 && !adc_rst_s2;

    always_ff @(posedge adc_clock) begin
        if (adc_rst_s2) begin
            req_tog <= 1'b0;
            cap_channel <= 2'h0;
            cap_temp <= '0;
        end else if (adc_valid && adc_ready) begin
            req_tog <= ~req_tog;
            cap_channel <= adc_channel;
            cap_temp <= adc_temp;
        end
    end

    always_ff @(posedge clock) begin
        req_s1 <= req_tog;
        req_s2 <= req_s1;
    end

    // The captured word stays stable until the acknowledge returns, so it is read directly.
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_tog <= 1'b0;
            res_valid <= 1'b0;
            res_channel <= 2'h0;
            res_temp <= '0;
        end else if (req_s2 != ack_tog) begin
            ack_tog <= req_s2;
            res_valid <= 1'b1;
            res_channel <= cap_channel;
            res_temp <= cap_temp;
        end else begin
            res_valid <= 1'b0;
        end
    end
endmodule // tsm_result_xfer
`default_nettype wire
